// >>> hw/sdf_pkg.sv
// Constants, register map and reset values of the Sinc3 decimation block.
// Assumes a 100 MHz system clock and a modulator sample strobe on it.
// Functional notes
// RULE1: 8-bit factor; decimation ratio is factor times eight
// RULE2: One result per eight-times-factor modulator samples
// RULE3: Valid factor 3 to 255 with chop off
// RULE4: Factor resets to 69 (45 hex)
// RULE5: Each factor step adds 0.244 ms period
// RULE6: Active-low chop bit at 1 disables chopping
// RULE7: After synchronized change, first result after three periods
// RULE8: Channel change restarts settling, suppresses output
// RULE9: Unsynchronized step: results keep flowing; fourth settles
// RULE10: Software recalibrates offset after gain or temperature change
// RULE11: Chop on: rate divided by three, factor clamped 13
// RULE12: Factor write restarts filter and settling
package sdf_pkg;
    localparam int          FACTOR_W        = 8;
    localparam int          RATIO_SHIFT     = 3;
    localparam int          RATIO_W         = FACTOR_W + RATIO_SHIFT;
    localparam int          ACC_W           = 34;
    localparam logic [7:0]  FACTOR_RESET    = 8'h45;
    localparam logic [7:0]  FACTOR_MIN_OFF  = 8'h03;
    localparam logic [7:0]  FACTOR_MIN_ON   = 8'h0d;
    localparam logic        CHOP_N_RESET    = 1'b1;
    localparam logic [1:0]  SETTLE_OUTPUTS  = 2'h2;
    localparam logic [1:0]  CHOP_PHASE_LAST = 2'h2;
    localparam int          MOD_RATE_HZ     = 32768;
    localparam int          STEP_TIME_NS    = 244000;
    localparam int          STEP_SAMPLES    = 8;
    localparam int          CLK_HZ          = 100000000;
    localparam int          MOD_PERIOD_CYC  = CLK_HZ / MOD_RATE_HZ;
    localparam logic [4:0]  OFS_FACTOR      = 5'h00;
    localparam logic [4:0]  OFS_CONTROL     = 5'h04;
    localparam logic [4:0]  OFS_STATUS      = 5'h08;
    localparam logic [4:0]  OFS_RESULT_LO   = 5'h0c;
    localparam logic [4:0]  OFS_RESULT_HI   = 5'h10;
    localparam int          CTRL_CHOP_N_BIT = 0;
    localparam int          CTRL_CHAN_BIT   = 1;
    localparam int          STAT_SETTLE_BIT = 0;
    localparam int          STAT_CHOP_BIT   = 1;
    localparam int          STAT_COUNT_LSB  = 16;
endpackage

// >>> hw/sdf_filt_if.sv
// Link between the control logic and the Sinc3 datapath.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sdf_filt_if #(
    parameter int ACC_W   = 34,
    parameter int RATIO_W = 11
);
    logic               sample_valid;
    logic               sample_bit;
    logic               restart;
    logic [RATIO_W-1:0] ratio;
    logic               out_valid;
    logic [ACC_W-1:0]   out_data;

    modport filt (
        input  sample_valid, sample_bit, restart, ratio,
        output out_valid, out_data
    );
    modport ctrl (
        output sample_valid, sample_bit, restart, ratio,
        input  out_valid, out_data
    );
endinterface
`default_nettype wire

// >>> hw/sdf_sinc3.sv
// Sinc3 integrate and dump datapath with programmable decimation ratio.
// Assumes one modulator bit per strobe and a ratio held between restarts.
`timescale 1ns/1ps
`default_nettype none
module sdf_sinc3 #(
    parameter int ACC_W   = 34,
    parameter int RATIO_W = 11
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    sdf_filt_if.filt  fb
);
    typedef struct packed {
        logic [ACC_W-1:0]   i1;
        logic [ACC_W-1:0]   i2;
        logic [ACC_W-1:0]   i3;
        logic [ACC_W-1:0]   d1;
        logic [ACC_W-1:0]   d2;
        logic [ACC_W-1:0]   d3;
        logic [RATIO_W-1:0] cnt;
        logic [ACC_W-1:0]   dout;
        logic               dvalid;
    } sdf_sinc_s;

    sdf_sinc_s st_reg;
    sdf_sinc_s st_next;

    if (ACC_W < 3 * RATIO_W + 1) begin : g_chk
        $error("Accumulator too narrow for ratio");
    end

    always_comb begin
        logic [ACC_W-1:0] c1;
        logic [ACC_W-1:0] c2;
        logic [ACC_W-1:0] c3;
        logic [ACC_W-1:0] i3n;
        c1 = '0;
        c2 = '0;
        c3 = '0;
        i3n = '0;
        st_next = st_reg;
        st_next.dvalid = 1'b0;
        if (fb.restart) begin
            st_next = '0;
        end else if (fb.sample_valid) begin
            st_next.i1 = st_reg.i1 + {{(ACC_W-1){1'b0}}, fb.sample_bit};
            st_next.i2 = st_reg.i2 + st_reg.i1;
            i3n = st_reg.i3 + st_reg.i2;
            st_next.i3 = i3n;
            if (st_reg.cnt >= fb.ratio - 1'b1) begin // RULE1 RULE2
                st_next.cnt = '0;
                c1 = i3n - st_reg.d1;
                c2 = c1 - st_reg.d2;
                c3 = c2 - st_reg.d3;
                st_next.d1 = i3n;
                st_next.d2 = c1;
                st_next.d3 = c2;
                st_next.dout = c3;
                st_next.dvalid = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fb.out_valid = st_reg.dvalid;
    assign fb.out_data  = st_reg.dout;
endmodule // sdf_sinc3
`default_nettype wire

// >>> hw/sdf_top.sv
// Sinc3 decimation control with Avalon-MM register slave.
// Assumes modulator strobe and channel-change pulse on clk_i.
`timescale 1ns/1ps
`default_nettype none
module sdf_top (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [2:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [3:0]  avs_byteenable_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        mod_valid_i,
    input  wire logic        mod_bit_i,
    input  wire logic        chan_change_i,
    output logic [sdf_pkg::ACC_W-1:0] result_data_o,
    output logic             result_valid_o,
    output logic             settling_o
);
    typedef struct packed {
        logic                         ack;
        logic [31:0]                  rdata;
        logic [sdf_pkg::FACTOR_W-1:0] factor;
        logic                         chop_n;
        logic [1:0]                   settle_cnt;
        logic                         settling;
        logic [1:0]                   phase;
        logic [sdf_pkg::ACC_W-1:0]    res;
        logic                         res_valid;
        logic [15:0]                  res_count;
        logic                         restart;
    } sdf_top_s;

    sdf_top_s st_reg;
    sdf_top_s st_next;

    localparam sdf_top_s ST_RESET = '{
        ack:        1'b0,
        rdata:      32'h0000_0000,
        factor:     sdf_pkg::FACTOR_RESET,  // RULE4
        chop_n:     sdf_pkg::CHOP_N_RESET,
        settle_cnt: 2'h0,
        settling:   1'b1,
        phase:      2'h0,
        res:        '0,
        res_valid:  1'b0,
        res_count:  16'h0000,
        restart:    1'b1
    };

    sdf_filt_if #(
        .ACC_W   (sdf_pkg::ACC_W),
        .RATIO_W (sdf_pkg::RATIO_W)
    ) fb ();

    // Effective factor after range clamp
    function automatic logic [7:0] eff_factor(input logic [7:0] f,
                                              input logic       chop_n);
        logic [7:0] lo;
        lo = chop_n ? sdf_pkg::FACTOR_MIN_OFF
                    : sdf_pkg::FACTOR_MIN_ON; // RULE6 RULE11
        eff_factor = (f < lo) ? lo : f; // RULE3 RULE11
    endfunction

    // Ratio is eight samples per factor step
    function automatic logic [sdf_pkg::RATIO_W-1:0] ratio_of(
        input logic [7:0] f,
        input logic       chop_n);
        ratio_of = {eff_factor(f, chop_n),
                    3'b000}; // RULE1 RULE5
    endfunction

    sdf_sinc3 #(
        .ACC_W   (sdf_pkg::ACC_W),
        .RATIO_W (sdf_pkg::RATIO_W)
    ) u_sinc3 (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .fb      (fb.filt)
    );

    assign fb.sample_valid = mod_valid_i;
    assign fb.sample_bit   = mod_bit_i;
    assign fb.restart      = st_reg.restart;
    assign fb.ratio        = ratio_of(st_reg.factor, st_reg.chop_n);

    always_comb begin
        logic [4:0]  addr;
        logic        req;
        logic        wr_go;
        logic        sync_chg;
        logic        deliver;
        logic [31:0] rd;
        addr = {avs_address_i, 2'b00};
        req = avs_read_i | avs_write_i;
        wr_go = avs_write_i & st_reg.ack;
        sync_chg = chan_change_i; // RULE8
        deliver = 1'b0;
        rd = 32'h0000_0000;
        st_next = st_reg;
        st_next.res_valid = 1'b0;
        st_next.restart = 1'b0;

        // One wait state, then complete
        st_next.ack = req & ~st_reg.ack;
        case (addr)
            sdf_pkg::OFS_FACTOR: begin
                rd = {24'h000000, st_reg.factor};
            end
            sdf_pkg::OFS_CONTROL: begin
                rd[sdf_pkg::CTRL_CHOP_N_BIT] = st_reg.chop_n;
            end
            sdf_pkg::OFS_STATUS: begin
                rd[sdf_pkg::STAT_SETTLE_BIT] = st_reg.settling;
                rd[sdf_pkg::STAT_CHOP_BIT] = ~st_reg.chop_n;
                rd[31:sdf_pkg::STAT_COUNT_LSB] = st_reg.res_count;
            end
            sdf_pkg::OFS_RESULT_LO: begin
                rd = st_reg.res[31:0];
            end
            sdf_pkg::OFS_RESULT_HI: begin
                rd = {30'h00000000, st_reg.res[sdf_pkg::ACC_W-1:32]};
            end
            default: begin
                rd = 32'h0000_0000;
            end
        endcase
        if (avs_read_i & ~st_reg.ack) begin
            st_next.rdata = rd;
        end

        if (wr_go && avs_byteenable_i[0]) begin
            case (addr)
                sdf_pkg::OFS_FACTOR: begin
                    st_next.factor = avs_writedata_i[7:0];
                    sync_chg = 1'b1; // RULE12
                end
                sdf_pkg::OFS_CONTROL: begin
                    st_next.chop_n =
                        avs_writedata_i[sdf_pkg::CTRL_CHOP_N_BIT];
                    if (avs_writedata_i[sdf_pkg::CTRL_CHAN_BIT] ||
                        avs_writedata_i[sdf_pkg::CTRL_CHOP_N_BIT]
                            != st_reg.chop_n) begin
                        sync_chg = 1'b1; // RULE8
                    end
                end
                default: begin
                end
            endcase
        end

        if (sync_chg) begin
            // Restart filter, hold results until settled
            st_next.restart = 1'b1; // RULE7 RULE8 RULE12
            st_next.settling = 1'b1;
            st_next.settle_cnt = 2'h0;
            st_next.phase = 2'h0;
        end else if (fb.out_valid && !st_reg.restart) begin
            // Output from before the restart is stale
            if (st_reg.settling) begin
                if (st_reg.settle_cnt == sdf_pkg::SETTLE_OUTPUTS) begin
                    st_next.settling = 1'b0; // RULE7
                    deliver = st_reg.chop_n;
                end else begin
                    st_next.settle_cnt = st_reg.settle_cnt + 2'h1;
                end
            end else begin
                // Unsynchronized steps are not detected
                deliver = st_reg.chop_n; // RULE9
            end
            if (!st_reg.chop_n) begin
                // One result per three filter outputs
                if (st_reg.phase == sdf_pkg::CHOP_PHASE_LAST) begin
                    st_next.phase = 2'h0;
                    deliver = ~st_reg.settling |
                        (st_reg.settle_cnt == sdf_pkg::SETTLE_OUTPUTS);
                end else begin
                    st_next.phase = st_reg.phase + 2'h1; // RULE11
                end
            end
        end

        if (deliver) begin
            st_next.res = fb.out_data; // RULE2
            st_next.res_valid = 1'b1;
            st_next.res_count = st_reg.res_count + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_reg.ack;
    assign avs_readdata_o    = st_reg.rdata;
    assign result_data_o     = st_reg.res;
    assign result_valid_o    = st_reg.res_valid;
    assign settling_o        = st_reg.settling;
endmodule // sdf_top
`default_nettype wire

// >>> sim/sdf_mod_model.sv
// Modulator bit stream model: one strobe every second clock.
// Assumes the same clock as the block and an enable from the bench.
`timescale 1ns/1ps
`default_nettype none
module sdf_mod_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic en_i,
    output logic      mod_valid_o,
    output logic      mod_bit_o
);
    // Fixed gain and temperature, so no offset calibration falls due
    logic [2:0] ph_reg;
    logic [4:0] pat_reg;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph_reg      <= 3'h0;
            pat_reg     <= 5'h15;
            mod_valid_o <= 1'b0;
            mod_bit_o   <= 1'b0;
        end else begin
            ph_reg      <= ph_reg + 3'h1;
            mod_valid_o <= en_i && ph_reg[0];
            if (ph_reg[0]) begin
                pat_reg   <= {pat_reg[3:0], pat_reg[4] ^ pat_reg[2]};
                mod_bit_o <= pat_reg[0];
            end else begin
                mod_bit_o <= ~mod_bit_o; // Bit not held past strobe
            end
        end
    end
endmodule // sdf_mod_model
`default_nettype wire

// >>> sim/sdf_top_monitor.sv
// Checker on the ports of the decimation block.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sdf_top_monitor (
    input wire logic                        clk_i,
    input wire logic                        rst_n_i,
    input wire logic [2:0]                  avs_address_i,
    input wire logic                        avs_read_i,
    input wire logic                        avs_write_i,
    input wire logic [3:0]                  avs_byteenable_i,
    input wire logic [31:0]                 avs_readdata_o,
    input wire logic                        avs_waitrequest_o,
    input wire logic                        mod_valid_i,
    input wire logic                        chan_change_i,
    input wire logic [sdf_pkg::ACC_W-1:0]   result_data_o,
    input wire logic                        result_valid_o,
    input wire logic                        settling_o
);
    logic [15:0] gap_reg;
    logic        req;
    assign req = avs_read_i | avs_write_i;
    // Samples since the last result
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) gap_reg <= 16'h0;
        else if (result_valid_o) gap_reg <= 16'(mod_valid_i);
        else gap_reg <= gap_reg + 16'(mod_valid_i);
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wait_one_a: assert property (req && avs_waitrequest_o |=>
        !avs_waitrequest_o) else $error("wait state too long");
    idle_wait_a: assert property (!req |-> !avs_waitrequest_o)
        else $error("waitrequest while idle");
    unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o
        && avs_address_i > 3'h4 |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    valid_pulse_a: assert property (
        result_valid_o |=> !result_valid_o)
        else $error("result pulse too long");
    data_hold_a: assert property (
        !result_valid_o |-> $stable(result_data_o))
        else $error("result changed without pulse");
    ratio_min_a: assert property (
        result_valid_o |-> gap_reg >= 16'd20)
        else $error("result after too few samples");
    chan_settle_a: assert property (
        chan_change_i |-> ##[1:3] settling_o)
        else $error("channel change did not settle");
    chan_quiet_a: assert property (
        chan_change_i |-> ##3 !result_valid_o [*8])
        else $error("result during settling");
    write_settle_a: assert property (avs_write_i &&
        !avs_waitrequest_o && avs_address_i == 3'h0 &&
        avs_byteenable_i[0] |-> ##[1:3] settling_o)
        else $error("factor write did not restart");
    cover property (result_valid_o);
    cover property (chan_change_i ##1 settling_o);
    cover property (settling_o ##1 !settling_o);
endmodule // sdf_top_monitor
bind sdf_top sdf_top_monitor i_sdf_top_monitor (.clk_i, .rst_n_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .mod_valid_i, .chan_change_i,
    .result_data_o, .result_valid_o, .settling_o);
`default_nettype wire

// >>> sim/test_sdf_top.sv
// Register and stream tests of the decimation block.
// Assumes the modulator model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_sdf_top;
    logic                      clk_i            = 1'b0;
    logic                      rst_n_i          = 1'b0;
    logic [2:0]                avs_address_i    = 3'h0;
    logic                      avs_read_i       = 1'b0;
    logic                      avs_write_i      = 1'b0;
    logic [3:0]                avs_byteenable_i = 4'hf;
    logic [31:0]               avs_writedata_i  = 32'h0;
    logic                      chan_change_i    = 1'b0;
    logic                      gen_en           = 1'b0;
    logic [31:0]               avs_readdata_o;
    logic                      avs_waitrequest_o;
    logic                      mod_valid_i;
    logic                      mod_bit_i;
    logic [sdf_pkg::ACC_W-1:0] result_data_o;
    logic                      result_valid_o;
    logic                      settling_o;
    logic [31:0]               rdata;
    int                        smp = 0;
    int                        mark = 0;
    int                        error_cnt = 0;
    int                        n_tests = 0;
    int                        n_res = 0;
    int                        s_cnt = 0;
    // Sinc3 gain at ratio 24: ratio cubed
    localparam logic [31:0]    GAIN3 = 32'h3600;
    sdf_top i_sdf_top (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o,
        .avs_waitrequest_o, .mod_valid_i, .mod_bit_i, .chan_change_i,
        .result_data_o, .result_valid_o, .settling_o);
    sdf_mod_model i_sdf_mod_model (.clk_i, .rst_n_i, .en_i(gen_en),
        .mod_valid_o(mod_valid_i), .mod_bit_o(mod_bit_i));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (mod_valid_i === 1'b1) smp <= smp + 1;
        if (result_valid_o === 1'b1) n_res <= n_res + 1;
    end
    task automatic chk(input string nm, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic [2:0] a, input logic w,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        chk("waitrequest", 32'h0, 32'(avs_waitrequest_o));
        rdata = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    // Samples from mark up to the next result pulse
    task automatic gap(output int s);
        int n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (result_valid_o !== 1'b1 && n < 20000);
        chk("result_valid", 32'h1, 32'(result_valid_o));
        s = smp - mark;
        mark = smp;
        @(negedge clk_i);
    endtask
    // Restart by write, or by channel pulse at address 7
    task automatic run(input logic [2:0] a, input logic [31:0] d,
                       input int r, input int per);
        int s;
        @(negedge clk_i);
        mark = smp;
        if (a == 3'h7) begin
            @(posedge clk_i);
            chan_change_i <= 1'b1;
            @(posedge clk_i);
            chan_change_i <= 1'b0;
        end else begin
            bus(a, 1'b1, d);
        end
        gap(s);
        chk("settle", 32'h1, 32'(s >= 3 * r && s <= 3 * r + 2));
        gap(s);
        chk("period", per, s);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #500000;
        error_cnt++;
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        gen_en <= 1'b1;
        @(posedge clk_i);
        bus(3'h0, 1'b0, 32'h0);
        chk("factor", 32'h45, rdata);
        bus(3'h1, 1'b0, 32'h0);
        chk("control", 32'h1, rdata);
        bus(3'h2, 1'b0, 32'h0);
        chk("status", 32'h1, rdata);
        bus(3'h7, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rdata);
        avs_byteenable_i <= 4'h0;
        bus(3'h0, 1'b1, 32'h9);
        avs_byteenable_i <= 4'hf;
        bus(3'h0, 1'b0, 32'h0);
        chk("lane_off", 32'h45, rdata);
        run(3'h0, 32'h3, 24, 24);
        chk("result_port", 32'h0, 32'(result_data_o > 34'(GAIN3)));
        bus(3'h3, 1'b0, 32'h0);
        chk("result_lo", 32'h1, 32'(rdata != 0 && rdata <= GAIN3));
        bus(3'h4, 1'b0, 32'h0);
        chk("result_hi", 32'h0, rdata);
        run(3'h0, 32'h4, 32, 32);
        run(3'h0, 32'hff, 2040, 2040);
        run(3'h0, 32'h2, 24, 24);
        chk("settled", 32'h0, 32'(settling_o));
        bus(3'h0, 1'b0, 32'h0);
        chk("readback", 32'h2, rdata);
        run(3'h7, 32'h0, 24, 24);
        gap(s_cnt);
        chk("flowing", 32'd24, s_cnt);
        chk("no_settle", 32'h0, 32'(settling_o));
        run(3'h1, 32'h3, 24, 24);
        run(3'h1, 32'h0, 104, 312);
        bus(3'h2, 1'b0, 32'h0);
        chk("chop", 32'h1, 32'(rdata[1]));
        chk("count", n_res, 32'(rdata[31:16]));
        // Reset in mid-run brings the defaults back
        rst_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        bus(3'h0, 1'b0, 32'h0);
        chk("reset_factor", 32'h45, rdata);
        bus(3'h1, 1'b0, 32'h0);
        chk("reset_control", 32'h1, rdata);
        wrap_up;
    end
endmodule // test_sdf_top
`default_nettype wire
